// >>> rtl/dio_totalizer.sv
// Dual 8-bit digital ports and gated pulse totalizer behind an APB slave
`default_nettype none
module dio_totalizer
  import dio_tot_pkg::*;
#(
  parameter int unsigned PORT_W = PORT_WIDTH,
  parameter int unsigned CNT_W  = COUNT_WIDTH,
  parameter int unsigned TS_W   = STAMP_WIDTH
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [DATA_WIDTH-1:0] pwdata,
  output logic      [DATA_WIDTH-1:0] prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [PORT_W-1:0]     port_in_lo,
  input  wire logic [PORT_W-1:0]     port_in_hi,
  output logic      [PORT_W-1:0]     port_out_lo,
  output logic      [PORT_W-1:0]     port_out_hi,
  output logic                       port_oe_n_lo,
  output logic                       port_oe_n_hi,
  input  wire logic                  pulse_in,
  input  wire logic                  gate_hi,
  input  wire logic                  gate_lo_n,
  output logic                       count_alarm,
  output logic                       pattern_alarm_lo,
  output logic                       pattern_alarm_hi
);

  // State of the block, apart from the synchroniser and pattern checker flops
  typedef struct packed {
    apb_st_t                      st;
    logic                         pready;
    logic                         pslverr;
    logic [DATA_WIDTH-1:0]        prdata;
    logic [1:0]                   scan;
    logic                         scan_cnt;
    logic                         slope_rise;
    logic                         read_and_clear_mode;
    logic                         cnt_al_en;
    logic [1:0]                   pat_en;
    logic [1:0]                   match_not_equal;
    logic [1:0]                   oe_n;
    logic [1:0][PORT_W-1:0]       out;
    logic [1:0][PORT_W-1:0]       pattern_compare_value;
    logic [1:0][PORT_W-1:0]       pattern_care_mask;
    logic [CNT_W-1:0]             count;
    logic [CNT_W-1:0]             limit;
    logic                         cnt_alarm;
    logic                         pulse_d;
    logic [TS_W-1:0]              stamp;
    logic [1:0][PORT_W-1:0]       snap_ports;
    logic [TS_W-1:0]              snap_stamp;
    logic [CNT_W-1:0]             snap_count;
  } state_t;

  state_t                 s_q;
  state_t                 s_d;

  logic [2*PORT_W+2:0]    pins_raw;
  logic [2*PORT_W+2:0]    pins_s;
  logic [1:0][PORT_W-1:0] port_s;
  logic                   pulse_s;
  logic                   gate_hi_s;
  logic                   gate_lo_n_s;
  logic [1:0]             pat_alarm;

  logic                   access;
  logic                   sel_hi;
  logic                   clr;
  logic                   edge_hit;
  logic                   gate_open;
  logic                   err;
  logic [DATA_WIDTH-1:0]  rdata;

  // Pin levels cross into the clock domain first
  assign pins_raw = {gate_lo_n, gate_hi, pulse_in, port_in_hi, port_in_lo};

  bit_sync #(
    .W (2*PORT_W+3)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pins_raw),
    .q       (pins_s)
  );

  assign port_s      = pins_s[2*PORT_W-1:0];
  assign pulse_s     = pins_s[2*PORT_W];
  assign gate_hi_s   = pins_s[2*PORT_W+1];
  assign gate_lo_n_s = pins_s[2*PORT_W+2];

  // One pattern checker per port, free of scan membership
  for (genvar g = 0; g < 2; g++) begin : g_pat
    pattern_alarm #(
      .W (PORT_W)
    ) u_pat (
      .pclk      (pclk),
      .presetn   (presetn),
      .value     (port_s[g]),
      .compare   (s_q.pattern_compare_value[g]),
      .care_mask (s_q.pattern_care_mask[g]),
      .not_equal (s_q.match_not_equal[g]),
      .enable    (s_q.pat_en[g]),
      .alarm     (pat_alarm[g])
    );
  end

  // Edge qualify: slope choice and both gates
  assign edge_hit  = s_q.slope_rise ? (pulse_s & ~s_q.pulse_d)
                                    : (~pulse_s & s_q.pulse_d);
  assign gate_open = gate_hi_s & ~gate_lo_n_s;

  // Register read mux, no side effects here
  always_comb begin
    rdata = '0;
    case (paddr)
      OFF_CTRL: begin
        rdata[CB_SCAN +: 2]       = s_q.scan;
        rdata[CB_SLOPE_RISE]      = s_q.slope_rise;
        rdata[CB_READ_CLEAR]      = s_q.read_and_clear_mode;
        rdata[CB_CNT_AL_EN]       = s_q.cnt_al_en;
        rdata[CB_PAT_EN +: 2]     = s_q.pat_en;
        rdata[CB_NOT_EQUAL +: 2]  = s_q.match_not_equal;
        rdata[CB_SCAN_CNT]        = s_q.scan_cnt;
      end
      OFF_PORT_LO: rdata[PORT_W-1:0] = port_s[0];
      OFF_PORT_HI: rdata[PORT_W-1:0] = port_s[1];
      OFF_WORD:    rdata[2*PORT_W-1:0] = (|s_q.scan) ? '0 : port_s;
      OFF_DIR:     rdata[1:0] = ~s_q.oe_n;
      OFF_CNT_READ, OFF_CNT_MON: rdata[CNT_W-1:0] = s_q.count;
      OFF_LIMIT:   rdata[CNT_W-1:0] = s_q.limit;
      OFF_PAT_LO: begin
        rdata[PAT_CMP_LSB +: PORT_W]  = s_q.pattern_compare_value[0];
        rdata[PAT_MASK_LSB +: PORT_W] = s_q.pattern_care_mask[0];
      end
      OFF_PAT_HI: begin
        rdata[PAT_CMP_LSB +: PORT_W]  = s_q.pattern_compare_value[1];
        rdata[PAT_MASK_LSB +: PORT_W] = s_q.pattern_care_mask[1];
      end
      OFF_STATUS: begin
        rdata[SB_SCAN +: 2]      = s_q.scan;
        rdata[SB_DRIVING +: 2]   = ~s_q.oe_n;
        rdata[SB_CNT_ALARM]      = s_q.cnt_alarm;
        rdata[SB_PAT_ALARM +: 2] = pat_alarm;
      end
      OFF_SNAP_PORTS: rdata[2*PORT_W-1:0] = s_q.snap_ports;
      OFF_SNAP_STAMP: rdata[TS_W-1:0]     = s_q.snap_stamp;
      OFF_SNAP_COUNT: rdata[CNT_W-1:0]    = s_q.snap_count;
      default:        rdata = '0;
    endcase
  end

  // Next state: bus access, commands, ports, totalizer
  always_comb begin
    s_d         = s_q;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.prdata  = '0;
    s_d.pulse_d = pulse_s;
    s_d.stamp   = s_q.stamp + TS_W'(1);
    access      = 1'b0;
    clr         = 1'b0;
    err         = 1'b0;
    sel_hi      = (paddr == OFF_PORT_HI);

    // Slave state: one wait cycle, then a registered answer
    case (s_q.st)
      ST_IDLE: begin
        if (psel && penable) begin
          access = 1'b1;
          s_d.st = ST_DONE;
        end
      end
      ST_DONE: s_d.st = ST_IDLE;
      default: s_d.st = ST_IDLE;
    endcase

    // Register writes
    if (access && pwrite) begin
      case (paddr)
        OFF_CTRL: begin
          for (int i = 0; i < 2; i++) begin
            if (pwdata[CB_SCAN + i] && !s_q.scan[i]) begin
              s_d.oe_n[i] = RST_OE_N;
              s_d.out[i]  = '0;
            end
          end
          s_d.scan                = pwdata[CB_SCAN +: 2];
          s_d.slope_rise          = pwdata[CB_SLOPE_RISE];
          s_d.read_and_clear_mode = pwdata[CB_READ_CLEAR];
          s_d.cnt_al_en           = pwdata[CB_CNT_AL_EN];
          s_d.pat_en              = pwdata[CB_PAT_EN +: 2];
          s_d.match_not_equal     = pwdata[CB_NOT_EQUAL +: 2];
          s_d.scan_cnt            = pwdata[CB_SCAN_CNT];
        end
        OFF_CMD: begin
          if (pwdata[CM_CARD_RESET]) begin
            s_d.oe_n = {2{RST_OE_N}};
            s_d.out  = '0;
            clr      = 1'b1;
          end
          if (pwdata[CM_LOCAL_RESET]) begin
            s_d.oe_n[pwdata[CM_LOCAL_SEL]] = RST_OE_N;
            s_d.out[pwdata[CM_LOCAL_SEL]]  = '0;
          end
          if (pwdata[CM_CLEAR_NOW]) begin
            clr = 1'b1;
          end
          if (pwdata[CM_SWEEP]) begin
            for (int i = 0; i < 2; i++) begin
              s_d.snap_ports[i] = s_q.scan[i] ? port_s[i] : '0;
            end
            s_d.snap_stamp = s_q.stamp;
            if (s_q.scan_cnt) begin
              s_d.snap_count = s_q.count;
              if (s_q.read_and_clear_mode) begin
                clr = 1'b1;
              end
            end
          end
        end
        OFF_PORT_LO, OFF_PORT_HI: begin
          if (s_q.scan[sel_hi]) begin
            err = 1'b1;
          end else begin
            s_d.out[sel_hi] = pwdata[PORT_W-1:0];
          end
        end
        OFF_WORD: begin
          if (|s_q.scan) begin
            err = 1'b1;
          end else begin
            s_d.out = pwdata[2*PORT_W-1:0];
          end
        end
        OFF_DIR: begin
          if (|(pwdata[1:0] & s_q.scan)) begin
            err = 1'b1;
          end else begin
            s_d.oe_n = ~pwdata[1:0];
          end
        end
        OFF_LIMIT: s_d.limit = pwdata[CNT_W-1:0];
        OFF_PAT_LO: begin
          s_d.pattern_compare_value[0] = pwdata[PAT_CMP_LSB +: PORT_W];
          s_d.pattern_care_mask[0]     = pwdata[PAT_MASK_LSB +: PORT_W];
        end
        OFF_PAT_HI: begin
          s_d.pattern_compare_value[1] = pwdata[PAT_CMP_LSB +: PORT_W];
          s_d.pattern_care_mask[1]     = pwdata[PAT_MASK_LSB +: PORT_W];
        end
        OFF_CNT_READ, OFF_CNT_MON, OFF_STATUS,
        OFF_SNAP_PORTS, OFF_SNAP_STAMP, OFF_SNAP_COUNT: err = 1'b0;
        default: err = 1'b1;
      endcase
    end

    // Register reads and their side effects
    if (access && !pwrite) begin
      case (paddr)
        OFF_WORD: err = |s_q.scan;
        OFF_CMD:  err = 1'b0;
        OFF_CNT_READ: begin
          if (s_q.read_and_clear_mode) begin
            clr = 1'b1;
          end
        end
        OFF_CNT_MON: clr = clr;
        default: begin
          if (paddr > OFF_SNAP_COUNT || paddr[1:0] != 2'b00) begin
            err = 1'b1;
          end
        end
      endcase
      s_d.prdata = err ? '0 : rdata;
    end

    if (access) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = err;
    end

    // Totalizer: clear first, then a coincident edge still counts, wraps at top
    s_d.count = (clr ? '0 : s_q.count)
              + CNT_W'(edge_hit & gate_open);

    // Count alarm watched every cycle
    s_d.cnt_alarm = s_q.cnt_al_en && (s_q.count >= s_q.limit);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.st   <= ST_IDLE;
      s_q.oe_n <= {2{RST_OE_N}};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign prdata           = s_q.prdata;
  assign pready           = s_q.pready;
  assign pslverr          = s_q.pslverr;
  assign port_out_lo      = s_q.out[0];
  assign port_out_hi      = s_q.out[1];
  assign port_oe_n_lo     = s_q.oe_n[0];
  assign port_oe_n_hi     = s_q.oe_n[1];
  assign count_alarm      = s_q.cnt_alarm;
  assign pattern_alarm_lo = pat_alarm[0];
  assign pattern_alarm_hi = pat_alarm[1];

endmodule // dio_totalizer
`default_nettype wire

// >>> rtl/dio_tot_pkg.sv
// Shared constants for the dual digital port and totalizer block
`default_nettype none
package dio_tot_pkg;

  // Structural widths
  localparam int unsigned PORT_WIDTH  = 8;
  localparam int unsigned COUNT_WIDTH = 26;
  localparam int unsigned STAMP_WIDTH = 32;
  localparam int unsigned DATA_WIDTH  = 32;
  localparam int unsigned ADDR_WIDTH  = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_CMD        = 8'h04;
  localparam logic [7:0] OFF_PORT_LO    = 8'h08;
  localparam logic [7:0] OFF_PORT_HI    = 8'h0c;
  localparam logic [7:0] OFF_WORD       = 8'h10;
  localparam logic [7:0] OFF_DIR        = 8'h14;
  localparam logic [7:0] OFF_CNT_READ   = 8'h18;
  localparam logic [7:0] OFF_CNT_MON    = 8'h1c;
  localparam logic [7:0] OFF_LIMIT      = 8'h20;
  localparam logic [7:0] OFF_PAT_LO     = 8'h24;
  localparam logic [7:0] OFF_PAT_HI     = 8'h28;
  localparam logic [7:0] OFF_STATUS     = 8'h2c;
  localparam logic [7:0] OFF_SNAP_PORTS = 8'h30;
  localparam logic [7:0] OFF_SNAP_STAMP = 8'h34;
  localparam logic [7:0] OFF_SNAP_COUNT = 8'h38;

  // Control register fields (two-bit fields: bit 0 lower port, bit 1 upper port)
  localparam int unsigned CB_SCAN       = 0;
  localparam int unsigned CB_SLOPE_RISE = 2;
  localparam int unsigned CB_READ_CLEAR = 3;
  localparam int unsigned CB_CNT_AL_EN  = 4;
  localparam int unsigned CB_PAT_EN     = 5;
  localparam int unsigned CB_NOT_EQUAL  = 7;
  localparam int unsigned CB_SCAN_CNT   = 9;

  // Command register fields, one-shots on write apart from the local reset select
  localparam int unsigned CM_CARD_RESET  = 0;
  localparam int unsigned CM_LOCAL_RESET = 1;
  localparam int unsigned CM_LOCAL_SEL   = 2;
  localparam int unsigned CM_CLEAR_NOW   = 3;
  localparam int unsigned CM_SWEEP       = 4;

  // Pattern register fields
  localparam int unsigned PAT_CMP_LSB  = 0;
  localparam int unsigned PAT_MASK_LSB = 8;

  // Status register fields
  localparam int unsigned SB_SCAN      = 0;
  localparam int unsigned SB_DRIVING   = 2;
  localparam int unsigned SB_CNT_ALARM = 4;
  localparam int unsigned SB_PAT_ALARM = 5;

  // Reset values
  localparam logic RST_OE_N = 1'b1;

  // Bus slave states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DONE = 2'b10
  } apb_st_t;

endpackage
`default_nettype wire

// >>> rtl/bit_sync.sv
// Two-flop synchroniser for a group of pin levels
`default_nettype none
module bit_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  // First stage feeds only the second
  always_comb begin
    s_d    = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.s2;

endmodule // bit_sync
`default_nettype wire

// >>> rtl/pattern_alarm.sv
// Masked pattern compare alarm for one digital port
`default_nettype none
module pattern_alarm #(
  parameter int unsigned W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] compare,
  input  wire logic [W-1:0] care_mask,
  input  wire logic         not_equal,
  input  wire logic         enable,
  output logic              alarm
);

  typedef struct packed {
    logic alarm;
  } alarm_st_t;

  alarm_st_t    s_q;
  alarm_st_t    s_d;
  logic [W-1:0] diff;

  // Xor with compare, keep only cared bits, then test
  always_comb begin
    s_d       = s_q;
    diff      = (value ^ compare) & care_mask;
    s_d.alarm = enable && (not_equal ? (|diff) : ~(|diff));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign alarm = s_q.alarm;

endmodule // pattern_alarm
`default_nettype wire

// >>> test/pin_side_model.sv
// Outside sources and loads on the digital port, pulse and gate pins
`default_nettype none
module pin_side_model (
  input  wire logic [7:0] port_out_lo,
  input  wire logic [7:0] port_out_hi,
  input  wire logic       port_oe_n_lo,
  input  wire logic       port_oe_n_hi,
  input  wire logic [7:0] ext_lo,
  input  wire logic [7:0] ext_hi,
  input  wire logic       pulse_lvl,
  input  wire logic       hi_wired,
  input  wire logic       hi_lvl,
  input  wire logic       lo_wired,
  input  wire logic       lo_lvl,
  output logic      [7:0] port_in_lo,
  output logic      [7:0] port_in_hi,
  output logic            pulse_in,
  output logic            gate_hi,
  output logic            gate_lo_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin level: the block while it drives, else the outside source
  assign port_in_lo = port_oe_n_lo ? ext_lo : port_out_lo;
  assign port_in_hi = port_oe_n_hi ? ext_hi : port_out_hi;
  assign pulse_in   = pulse_lvl;
  // Open gate terminals float to their enabling level
  assign gate_hi    = hi_wired ? hi_lvl : 1'b1;
  assign gate_lo_n  = lo_wired ? lo_lvl : 1'b0;
endmodule // pin_side_model
`default_nettype wire

// >>> test/dio_totalizer_properties.sv
// Bus and pin assertions for the dual port and totalizer block
`default_nettype none
module dio_totalizer_properties
  import dio_tot_pkg::*;
#(
  parameter int unsigned PORT_W = 8
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [DATA_WIDTH-1:0] pwdata,
  input wire logic [DATA_WIDTH-1:0] prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [PORT_W-1:0]     port_out_lo,
  input wire logic [PORT_W-1:0]     port_out_hi,
  input wire logic                  port_oe_n_lo,
  input wire logic                  port_oe_n_hi,
  input wire logic                  gate_hi,
  input wire logic                  count_alarm
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // First access edge of a write to one register
  sequence wr_take(logic [7:0] a);
    psel && penable && pwrite && !pready && paddr == a;
  endsequence
  // Accepted answer
  sequence ok_ans;
    pready && !pslverr;
  endsequence
  AST_ONE_WAIT:
    assert property ($rose(penable) && psel |=> pready) else $error("pready late");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("pready too long");
  AST_NO_READY_IDLE:
    assert property (!psel |=> !pready) else $error("pready without access");
  AST_ERR_WITH_READY:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_SCAN_INPUT:
    assert property (wr_take(OFF_CTRL) ##0 pwdata[CB_SCAN] ##1 ok_ans
      |-> port_oe_n_lo && port_out_lo == '0) else $error("scanned port not input");
  AST_DIR_DRIVE:
    assert property (wr_take(OFF_DIR) ##1 ok_ans
      |-> port_oe_n_lo == !pwdata[0] && port_oe_n_hi == !pwdata[1]) else $error("dir");
  AST_BYTE_WRITE:
    assert property (wr_take(OFF_PORT_HI) ##1 ok_ans |-> port_out_hi == pwdata[7:0])
      else $error("byte write");
  AST_WORD_WRITE:
    assert property (wr_take(OFF_WORD) ##1 ok_ans
      |-> {port_out_hi, port_out_lo} == pwdata[15:0]) else $error("word write");
  AST_WORD_UPPER:
    assert property (pready && !pwrite && paddr == OFF_WORD |-> prdata[31:16] == '0)
      else $error("word read upper bits");
  AST_OE_BY_WRITE:
    assert property ($changed({port_oe_n_hi, port_oe_n_lo})
      |-> $past(psel) && $past(penable) && $past(pwrite)) else $error("dir moved");
  AST_GATE_BLOCKS:
    assert property ((!gate_hi && !psel)[*8] |-> $stable(count_alarm))
      else $error("count moved with gate closed");
endmodule // dio_totalizer_properties
bind dio_totalizer dio_totalizer_properties #(.PORT_W(PORT_W)) props_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .port_out_lo, .port_out_hi, .port_oe_n_lo, .port_oe_n_hi, .gate_hi,
  .count_alarm
);
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the dual port and totalizer block
`default_nettype none
module tb_top
  import dio_tot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic [7:0]  ext_lo    = 8'h00;
  logic [7:0]  ext_hi    = 8'h00;
  logic        pulse_lvl = 1'b0;
  logic        hi_wired  = 1'b0;
  logic        hi_lvl    = 1'b0;
  logic        lo_wired  = 1'b0;
  logic        lo_lvl    = 1'b0;
  logic [31:0] prdata;
  logic [7:0]  port_in_lo, port_in_hi, port_out_lo, port_out_hi;
  logic        pready, pslverr, port_oe_n_lo, port_oe_n_hi, pulse_in, gate_hi, gate_lo_n;
  logic        count_alarm, pattern_alarm_lo, pattern_alarm_hi;
  int          fails      = 0;
  int          num_checks = 0;
  int          cyc        = 0;

  dio_totalizer dio_totalizer_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .port_in_lo, .port_in_hi, .port_out_lo, .port_out_hi, .port_oe_n_lo,
    .port_oe_n_hi, .pulse_in, .gate_hi, .gate_lo_n, .count_alarm, .pattern_alarm_lo,
    .pattern_alarm_hi
  );
  pin_side_model pin_side_model_inst (
    .port_out_lo, .port_out_hi, .port_oe_n_lo, .port_oe_n_hi, .ext_lo, .ext_hi,
    .pulse_lvl, .hi_wired, .hi_lvl, .lo_wired, .lo_lvl, .port_in_lo, .port_in_hi,
    .pulse_in, .gate_hi, .gate_lo_n
  );

  // Clock
  initial begin
    forever #5 pclk = ~pclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 10000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits for pready, with no time limit but the hang guard
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic        g;
    xfer(1'b1, a, d, r, g);
    chk("write pslverr", 32'(e), 32'(g));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic e);
    logic [31:0] r;
    logic        g;
    xfer(1'b0, a, 32'h0, r, g);
    chk("prdata", x, r);
    chk("read pslverr", 32'(e), 32'(g));
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      pulse_lvl <= 1'b1;
      repeat (5) @(posedge pclk);
      pulse_lvl <= 1'b0;
      repeat (5) @(posedge pclk);
    end
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    // Reset state and bus refusals
    chk("oe", 32'h3, 32'({port_oe_n_hi, port_oe_n_lo}));
    rd(OFF_CNT_MON, 32'h0, 1'b0);
    rd(8'h3c, 32'h0, 1'b1);
    // Word and byte writes, loopback reads
    wr(OFF_DIR, 32'h3, 1'b0);
    wr(OFF_WORD, 32'h2857, 1'b0);
    chk("out", 32'h2857, 32'({port_out_hi, port_out_lo}));
    rd(OFF_WORD, 32'h2857, 1'b0);
    wr(OFF_PORT_HI, 32'ha5, 1'b0);
    rd(OFF_PORT_LO, 32'h57, 1'b0);
    rd(OFF_PORT_HI, 32'ha5, 1'b0);
    // Lower port joins the scan
    ext_lo <= 8'h92;
    wr(OFF_CTRL, 32'h1, 1'b0);
    chk("oe", 32'h1, 32'({port_oe_n_hi, port_oe_n_lo}));
    wr(OFF_PORT_LO, 32'h11, 1'b1);
    wr(OFF_WORD, 32'h1111, 1'b1);
    wr(OFF_DIR, 32'h3, 1'b1);
    chk("out", 32'ha500, 32'({port_out_hi, port_out_lo}));
    rd(OFF_WORD, 32'h0, 1'b1);
    rd(OFF_PORT_LO, 32'h92, 1'b0);
    // Pattern alarms, equal then not-equal
    wr(OFF_PAT_LO, 32'hf080, 1'b0);
    wr(OFF_PAT_HI, 32'hf0a0, 1'b0);
    wr(OFF_CTRL, 32'h61, 1'b0);
    chk("pattern", 32'h2, 32'({pattern_alarm_hi, pattern_alarm_lo}));
    wr(OFF_CTRL, 32'h1e1, 1'b0);
    chk("pattern", 32'h1, 32'({pattern_alarm_hi, pattern_alarm_lo}));
    // Both ports scanned, one sweep
    ext_hi <= 8'h3c;
    wr(OFF_CTRL, 32'h3, 1'b0);
    repeat (4) @(posedge pclk);
    wr(OFF_CMD, 32'h10, 1'b0);
    rd(OFF_SNAP_PORTS, 32'h3c92, 1'b0);
    // Local reset of the upper port, then card reset
    wr(OFF_CTRL, 32'h0, 1'b0);
    wr(OFF_DIR, 32'h3, 1'b0);
    wr(OFF_CMD, 32'h6, 1'b0);
    chk("oe", 32'h2, 32'({port_oe_n_hi, port_oe_n_lo}));
    wr(OFF_DIR, 32'h3, 1'b0);
    wr(OFF_CMD, 32'h1, 1'b0);
    chk("oe", 32'h3, 32'({port_oe_n_hi, port_oe_n_lo}));
    // Local reset of the lower port leaves the upper one driving
    wr(OFF_DIR, 32'h3, 1'b0);
    wr(OFF_CMD, 32'h2, 1'b0);
    chk("oe", 32'h1, 32'({port_oe_n_hi, port_oe_n_lo}));
    // Totalizer with open gates, rising edges
    wr(OFF_CTRL, 32'h4, 1'b0);
    pulses(3);
    rd(OFF_CNT_MON, 32'h3, 1'b0);
    rd(OFF_CNT_MON, 32'h3, 1'b0);
    // Alarm armed above the gated count, so both edges leaking would raise it
    wr(OFF_LIMIT, 32'h5, 1'b0);
    wr(OFF_CTRL, 32'h14, 1'b0);
    hi_wired <= 1'b1;
    pulses(2);
    rd(OFF_CNT_MON, 32'h3, 1'b0);
    chk("count_alarm", 32'h0, 32'(count_alarm));
    hi_lvl   <= 1'b1;
    lo_wired <= 1'b1;
    lo_lvl   <= 1'b1;
    pulses(2);
    rd(OFF_CNT_MON, 32'h3, 1'b0);
    lo_lvl <= 1'b0;
    pulses(1);
    rd(OFF_CNT_MON, 32'h4, 1'b0);
    // Falling slope counts only the fall
    wr(OFF_CTRL, 32'h0, 1'b0);
    pulse_lvl <= 1'b1;
    repeat (5) @(posedge pclk);
    rd(OFF_CNT_MON, 32'h4, 1'b0);
    pulse_lvl <= 1'b0;
    repeat (5) @(posedge pclk);
    rd(OFF_CNT_MON, 32'h5, 1'b0);
    // Read-and-clear against plain reads
    wr(OFF_CTRL, 32'h8, 1'b0);
    rd(OFF_CNT_READ, 32'h5, 1'b0);
    rd(OFF_CNT_MON, 32'h0, 1'b0);
    wr(OFF_CTRL, 32'h4, 1'b0);
    pulses(2);
    rd(OFF_CNT_READ, 32'h2, 1'b0);
    rd(OFF_CNT_READ, 32'h2, 1'b0);
    wr(OFF_CTRL, 32'h20c, 1'b0);
    wr(OFF_CMD, 32'h10, 1'b0);
    rd(OFF_SNAP_COUNT, 32'h2, 1'b0);
    rd(OFF_CNT_MON, 32'h0, 1'b0);
    pulses(1);
    wr(OFF_CMD, 32'h8, 1'b0);
    rd(OFF_CNT_MON, 32'h0, 1'b0);
    // Count alarm at the programmed limit
    wr(OFF_LIMIT, 32'h3, 1'b0);
    wr(OFF_CTRL, 32'h14, 1'b0);
    pulses(2);
    chk("count_alarm", 32'h0, 32'(count_alarm));
    pulses(1);
    chk("count_alarm", 32'h1, 32'(count_alarm));
    wr(OFF_CMD, 32'h1, 1'b0);
    rd(OFF_CNT_MON, 32'h0, 1'b0);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
